// file: src/txpis_loader.sv
// image loader that selects the transmit pll reference index for one channel
`timescale 1ns/100ps
`default_nettype none
`include "txpis_cfg.svh"
module txpis_loader (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // override pins from user logic
  input wire logic [1:0] tx_pll_idx_ovr,
  input wire logic tx_pll_idx_ovr_en,
  // image index and channel address for the write
  input wire logic [1:0] image_pll_idx,
  input wire logic [7:0] target_channel,
  input wire logic [2:0] reconfig_mode,
  // channel side
  output logic [7:0] applied_channel,
  output logic [1:0] applied_pll_idx,
  output logic apply_strobe,
  output logic [2:0] applied_mode,
  output logic reconfig_done
);
  // =====================================================
  // pin synchronisers
  logic [1:0] ovr_s1_ff;
  logic [1:0] ovr_s2_ff;
  logic ovr_en_s1_ff;
  logic ovr_en_s2_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_s1_ff <= 2'h0;
      ovr_s2_ff <= 2'h0;
      ovr_en_s1_ff <= 1'b0;
      ovr_en_s2_ff <= 1'b0;
    end else begin
      ovr_s1_ff <= tx_pll_idx_ovr;
      ovr_s2_ff <= ovr_s1_ff;
      ovr_en_s1_ff <= tx_pll_idx_ovr_en;
      ovr_en_s2_ff <= ovr_en_s1_ff;
    end
  end

  // =====================================================
  // registers
  txpis_pkg::txpis_state_t state_ff;
  logic ovr_pres_ff;
  logic ovr_en_pres_ff;
  logic hip_used_ff;
  logic done_ff;
  logic refused_ff;
  logic [3:0] word_cnt_ff;
  logic [1:0] sel_idx_ff;
  logic [7:0] chan_ff;
  logic [2:0] mode_ff;
  logic [31:0] rdata_ff;
  logic wr_acc;
  logic rd_acc;
  logic start_req;
  logic [1:0] nxt_idx;
  logic hip_req;
  logic last_word;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign start_req = wr_acc && (paddr == `TXPIS_REG_CTRL) && pwdata[`TXPIS_CTRL_START];
  // the hard core bit of the start write itself decides, so one write cannot slip past it
  assign hip_req = pwdata[`TXPIS_CTRL_HIP];
  assign last_word = (state_ff == txpis_pkg::TXPIS_WRITE) && (word_cnt_ff == 4'h1);
  // zero wait states: every register answers from flops captured in setup
  assign pready = 1'b1;
  // unaligned or past the last register: flag it, never decode it
  assign pslverr = psel && penable && (paddr[1:0] != 2'b00 || paddr > `TXPIS_REG_LAST);

  // index choice per presence and enable
  always_comb begin
    if (ovr_pres_ff && ovr_en_pres_ff) begin
      nxt_idx = ovr_en_s2_ff ? ovr_s2_ff : image_pll_idx;
    end else if (ovr_pres_ff) begin
      nxt_idx = ovr_s2_ff;
    end else begin
      nxt_idx = image_pll_idx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_pres_ff <= 1'b0;
      ovr_en_pres_ff <= 1'b0;
      hip_used_ff <= 1'b0;
    end else if (wr_acc && paddr == `TXPIS_REG_CTRL) begin
      hip_used_ff <= pwdata[`TXPIS_CTRL_HIP];
    end else if (wr_acc && paddr == `TXPIS_REG_OVR) begin
      ovr_pres_ff <= pwdata[`TXPIS_OVR_PRES];
      ovr_en_pres_ff <= pwdata[`TXPIS_OVR_EN_PRES];
    end
  end

  // =====================================================
  // write sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= txpis_pkg::TXPIS_IDLE;
      word_cnt_ff <= 4'h0;
      sel_idx_ff <= `TXPIS_IDX_RST;
      chan_ff <= `TXPIS_CH_RST;
      mode_ff <= 3'h0;
    end else begin
      case (state_ff)
        txpis_pkg::TXPIS_IDLE: begin
          // a hard pci express core locks the channel out
          if (start_req && !hip_req) begin
            sel_idx_ff <= nxt_idx;
            chan_ff <= target_channel;
            mode_ff <= reconfig_mode;
            word_cnt_ff <= `TXPIS_WORDS;
            state_ff <= txpis_pkg::TXPIS_WRITE;
          end
        end
        txpis_pkg::TXPIS_WRITE: begin
          word_cnt_ff <= word_cnt_ff - 4'h1;
          if (word_cnt_ff == 4'h1) begin
            state_ff <= txpis_pkg::TXPIS_DONE;
          end
        end
        txpis_pkg::TXPIS_DONE: begin
          state_ff <= txpis_pkg::TXPIS_IDLE;
        end
        default: begin
          state_ff <= txpis_pkg::TXPIS_IDLE;
        end
      endcase
    end
  end

  // only the channel, the transmit clock source index and the mode are driven; receiver fields have no path here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_channel <= `TXPIS_CH_RST;
      applied_pll_idx <= `TXPIS_IDX_RST;
      applied_mode <= 3'h0;
      apply_strobe <= 1'b0;
    end else begin
      apply_strobe <= last_word;
      if (last_word) begin
        applied_channel <= chan_ff;
        applied_pll_idx <= sel_idx_ff;
        applied_mode <= mode_ff;
      end
    end
  end

  // completion and refusal flags: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      if (state_ff == txpis_pkg::TXPIS_DONE) begin
        done_ff <= 1'b1;
      end else if (start_req) begin
        done_ff <= 1'b0;
      end
      if (start_req && hip_req) begin
        refused_ff <= 1'b1;
      end else if (wr_acc && paddr == `TXPIS_REG_STAT && pwdata[`TXPIS_STAT_REFUSED]) begin
        refused_ff <= 1'b0;
      end
    end
  end
  assign reconfig_done = done_ff;

  // =====================================================
  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      // start is write-only: it reads back as zero
      case (paddr)
        `TXPIS_REG_CTRL: begin
          rdata_ff <= {30'h0, hip_used_ff, 1'b0};
        end
        `TXPIS_REG_OVR: begin
          rdata_ff <= {27'h0, ovr_en_pres_ff, ovr_pres_ff, ovr_en_s2_ff, ovr_s2_ff};
        end
        `TXPIS_REG_STAT: begin
          rdata_ff <= {29'h0, refused_ff, done_ff, state_ff != txpis_pkg::TXPIS_IDLE};
        end
        `TXPIS_REG_LAST: begin
          rdata_ff <= {22'h0, sel_idx_ff, chan_ff};
        end
        default: begin
          rdata_ff <= 32'h0;
        end
      endcase
    end
  end
  assign prdata = rd_acc ? rdata_ff : 32'h0;
endmodule
`default_nettype wire

// file: src/txpis_cfg.svh
// constants for the transmit pll index select loader
`ifndef TXPIS_CFG_SVH
`define TXPIS_CFG_SVH
`define TXPIS_REG_CTRL 12'h000
`define TXPIS_REG_OVR 12'h004
`define TXPIS_REG_STAT 12'h008
`define TXPIS_REG_LAST 12'h00c
`define TXPIS_CTRL_START 0
`define TXPIS_CTRL_HIP 1
`define TXPIS_OVR_EN 2
`define TXPIS_OVR_PRES 3
`define TXPIS_OVR_EN_PRES 4
`define TXPIS_STAT_BUSY 0
`define TXPIS_STAT_DONE 1
`define TXPIS_STAT_REFUSED 2
`define TXPIS_WORDS 4'h8
`define TXPIS_CH_RST 8'h00
`define TXPIS_IDX_RST 2'h0
`endif

// file: src/txpis_pkg.sv
// types for the transmit pll index select loader
`default_nettype none
package txpis_pkg;
  typedef enum logic [2:0] {
    TXPIS_IDLE = 3'b001,
    TXPIS_WRITE = 3'b010,
    TXPIS_DONE = 3'b100
  } txpis_state_t;
endpackage
`default_nettype wire

// file: tb/txpis_chk.sv
// port assertions for the transmit pll index select loader
`timescale 1ns/100ps
`default_nettype none
module txpis_chk (
  // watched ports
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic apply_strobe, reconfig_done,
  input wire logic [1:0] applied_pll_idx,
  input wire logic [7:0] applied_channel
);
  // ====
  // start write with the pcie bit clear
  wire logic st = psel && penable && pwrite && paddr == 12'h000 && pwdata[1:0] == 2'b01;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_now_a: assert property (psel |-> pready) else $error("ready low");
  bad_addr_a: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
    else $error("no slave error");
  rd_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read");
  strobe_one_a: assert property (apply_strobe |=> !apply_strobe)
    else $error("long strobe");
  start_apply_a: assert property (st |-> ##[6:10] apply_strobe)
    else $error("no apply");
  done_clear_a: assert property (st |=> !reconfig_done)
    else $error("done kept");
  done_after_a: assert property (apply_strobe |-> ##[1:3] reconfig_done)
    else $error("no done");
  apply_hold_a: assert property (!apply_strobe |-> $stable(applied_pll_idx) &&
    $stable(applied_channel)) else $error("apply moved");
  cover property (st);
  cover property (apply_strobe);
  cover property (psel && penable && pslverr);
endmodule
bind txpis_loader txpis_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
  .paddr, .pwdata, .prdata, .apply_strobe, .reconfig_done, .applied_pll_idx, .applied_channel);
`default_nettype wire

// file: tb/txpis_user.sv
// user logic model driving the override pins and write selectors
`timescale 1ns/100ps
`default_nettype none
module txpis_user (
  // control
  input wire logic pclk, presetn, load,
  input wire logic [15:0] req,
  // pins
  output logic [1:0] tx_pll_idx_ovr, image_pll_idx,
  output logic tx_pll_idx_ovr_en,
  output logic [7:0] target_channel,
  output logic [2:0] reconfig_mode
);
  // only load moves the pins, so they stay put through a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tx_pll_idx_ovr, tx_pll_idx_ovr_en, image_pll_idx, target_channel, reconfig_mode} <= 16'h0;
    end else if (load) begin
      {tx_pll_idx_ovr, tx_pll_idx_ovr_en, image_pll_idx, target_channel, reconfig_mode} <= req;
    end
  end
endmodule
`default_nettype wire

// file: tb/test_tx_pll_index_select_reconfig.sv
// self-checking bench for the transmit pll index select loader
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_tx_pll_index_select_reconfig;
  // ====
  localparam logic [2:0] MODE_CH_PLL = 3'h1, MODE_CCU = 3'h2;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, load = 0, err_r;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic [15:0] req = 16'h0;
  logic pready, pslverr, tx_pll_idx_ovr_en, apply_strobe, reconfig_done;
  logic [1:0] tx_pll_idx_ovr, image_pll_idx, applied_pll_idx, ex;
  logic [7:0] target_channel, applied_channel, c;
  logic [2:0] reconfig_mode, applied_mode, m;
  logic [12:0] e;
  logic [12:0] exp_q[$];
  // reference choice of index, from presence, enable and pin levels
  function automatic logic [1:0] model_idx(input int pres, en_pres, en, ovr, img);
    if (pres != 0 && (en_pres == 0 || en != 0)) return 2'(ovr);
    return 2'(img);
  endfunction
  int err_count = 0, compares = 0, cyc = 0;
  txpis_loader u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_pll_idx_ovr, .tx_pll_idx_ovr_en, .image_pll_idx, .target_channel,
    .reconfig_mode, .applied_channel, .applied_pll_idx, .apply_strobe, .applied_mode,
    .reconfig_done);
  txpis_user u_user (.pclk, .presetn, .load, .req, .tx_pll_idx_ovr, .image_pll_idx,
    .tx_pll_idx_ovr_en, .target_channel, .reconfig_mode);
  initial forever #50 pclk = ~pclk;
  task stop_test;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ceiling well above twelve loads of some thirty cycles each
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      stop_test;
    end
  end
  // ====
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err_r = pslverr;
    psel <= 0; penable <= 0;
  endtask
  initial begin
    void'($urandom(32'hd6c5f4f3));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(1, 12'h000, 32'h3);
    apb(0, 12'h008, 32'h0);
    `CHK(rd[2:0], 3'b100)
    apb(1, 12'h008, 32'h4);
    apb(1, 12'h000, 32'h0);
    apb(0, 12'h010, 32'h0);
    `CHK(err_r, 1'b1)
    for (int i = 0; i < 12; i++) begin
      r = $urandom;
      m = i < 4 ? MODE_CH_PLL : (i == 4 ? MODE_CCU : r[2:0]);
      c = i < 4 ? 8'(i) : r[10:3];
      ex = model_idx(r[16], r[17], r[13], r[15:14], r[12:11]);
      exp_q.push_back({ex, c, m});
      @(posedge pclk);
      req <= {r[15:11], c, m};
      load <= 1;
      @(posedge pclk);
      load <= 0;
      repeat (3) @(posedge pclk);
      apb(1, 12'h004, {27'h0, r[17], r[16], 3'h0});
      apb(0, 12'h004, 32'h0);
      `CHK(rd[4:0], ({r[17:16], r[13], r[15:14]}))
      apb(1, 12'h000, 32'h1);
      for (int k = 0; k < 20 && apply_strobe !== 1'b1; k++) @(negedge pclk);
      e = exp_q.pop_front();
      `CHK(apply_strobe, 1'b1)
      `CHK(reconfig_done, 1'b0)
      `CHK(applied_pll_idx, e[12:11])
      `CHK(({applied_channel, applied_mode}), e[10:0])
      for (int k = 0; k < 20 && reconfig_done !== 1'b1; k++) @(negedge pclk);
      apb(0, 12'h008, 32'h0);
      `CHK(rd[2:0], 3'b010)
      apb(0, 12'h00c, 32'h0);
      `CHK(rd[9:0], ({ex, c}))
    end
    stop_test;
  end
endmodule
`default_nettype wire
